// file: verilog/flash_cfg_defs.svh
// Register offsets, reset values, field positions and decode constants.
// Assumes it is included by bare name wherever a register constant is needed.
`ifndef FLASH_CFG_DEFS_SVH
`define FLASH_CFG_DEFS_SVH

// Register offsets on the serial port.
`define REG_LED2_TORCH 8'h06
`define REG_BOOST 8'h07
`define REG_TIMING 8'h08
`define REG_THERM 8'h09

// Reset values of the stored (non-reserved) bits.
`define RST_LED2_LEVEL 7'h3F
`define RST_BOOST 4'h9
`define RST_TIMING 7'h1A
`define RST_THERM 7'h08

// Field positions.
`define LEVEL_MSB 6
`define BOOST_SWRST 7
`define BOOST_SHORT 3
`define BOOST_PASS 2
`define BOOST_FREQ 1
`define BOOST_ILIM 0
`define RAMP_MSB 6
`define RAMP_LSB 4
`define TMO_MSB 3
`define TMO_LSB 0
`define THERM_POL 6
`define THERM_OPEN 5
`define THERM_SHORT 4
`define THRESH_MSB 3
`define THRESH_LSB 1
`define THERM_FUNC 0

// Decode constants, times in ms and thresholds in tenths of a volt.
`define TMO_FINE_STEP 11'd10
`define TMO_FINE_LAST 4'd9
`define TMO_FINE_TOP 11'd100
`define TMO_COARSE_STEP 11'd50
`define TMO_EXT_SHIFT 2
`define RAMP_SHORT_MS 11'd1
`define RAMP_BASE_MS 11'd32
`define THRESH_BASE_DV 4'd2

// Serial port framing.
`define BITS_PER_BYTE 4'd8
`define RW_BIT 0

`endif

// file: verilog/flash_cfg_pkg.sv
// Types shared by the configuration slice.
// Assumes flash_cfg_defs.svh supplies the numeric constants.
package flash_cfg_pkg;
    // Torch current code and millisecond values.
    typedef logic [6:0] level_t;
    typedef logic [10:0] ms_t;
    typedef logic [3:0] dv_t;
    // Serial port states, one-hot.
    typedef enum logic [8:0] {
        ST_IDLE = 9'h001,
        ST_ADDR = 9'h002,
        ST_ADDR_ACK = 9'h004,
        ST_PTR = 9'h008,
        ST_PTR_ACK = 9'h010,
        ST_WDATA = 9'h020,
        ST_WDATA_ACK = 9'h040,
        ST_RDATA = 9'h080,
        ST_RDATA_ACK = 9'h100
    } port_state_e;
endpackage

// file: verilog/flash_cfg_regs.sv
// Configuration registers of a dual flash LED driver behind a two-wire serial port.
// Assumes SCL_IN and SDA_IN are already synchronous to CORE_CLK and far slower than it.
//
// Functional notes
// - Second torch level: seven bits, default 0111111.
// - Boost bit 7 write one resets device.
// - Boost bit 3 enables LED short detection.
// - Boost bit 2 selects pass-through only.
// - Boost bit 1 selects 4 MHz switching.
// - Boost bit 0 selects 2.8 A limit.
// - Flash time-out decodes 10 ms, then 50 ms.
// - Extended variant multiplies every time-out by four.
// - Thermistor bit 6 sets torch polarity, pull-down.
// - Thermistor bit 5 enables open fault report.
// - Thermistor bit 4 enables short fault report.
// - Thermistor bit 0 selects temperature sensing function.
`timescale 1ns/100ps
`include "flash_cfg_defs.svh"

module flash_cfg_regs #(
    parameter logic [6:0] DEV_ADDR = 7'h10,    // Arbitrary bus address.
    parameter bit EXT_TIMEOUT = 1'b0           // Set on the extended time-out variant.
) (
    input wire logic CORE_CLK,
    input wire logic RESETN,
    input wire logic SCL_IN,
    input wire logic SDA_IN,
    output logic SDA_OUT,
    output logic SDA_OE,
    output flash_cfg_pkg::level_t TORCH_CURRENT_SETTING,
    output logic SOFT_RESET,
    output logic SHORT_DETECT_EN,
    output logic PASS_MODE,
    output logic FREQ_4MHZ,
    output logic ILIM_HIGH,
    output flash_cfg_pkg::ms_t TORCH_RAMP_MS,
    output flash_cfg_pkg::ms_t FLASH_TIMEOUT_MS,
    output logic TORCH_ACTIVE_LOW,
    output logic TORCH_PULLDOWN_EN,
    output logic THERMISTOR_OPEN_EN,
    output logic THERMISTOR_SHORT_EN,
    output flash_cfg_pkg::dv_t TEMP_THRESHOLD_DV,
    output logic PIN_TEMP_SENSE
);
    import flash_cfg_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    // Decode functions.

    // Flash time-out in ms; fine steps up to code 9, coarse steps above.
    function automatic ms_t timeout_ms(input logic [3:0] code, input bit ext);
        ms_t base;
        if (code <= `TMO_FINE_LAST) begin
            base = 11'(({7'd0, code} + 11'd1) * `TMO_FINE_STEP);
        end else begin
            base = 11'(`TMO_FINE_TOP + {7'd0, code - `TMO_FINE_LAST} * `TMO_COARSE_STEP);
        end
        timeout_ms = ext ? 11'(base << `TMO_EXT_SHIFT) : base;
    endfunction

    // Torch ramp in ms; doubling from the base above the two short codes.
    function automatic ms_t ramp_ms(input logic [2:0] code);
        case (code)
            3'h0: ramp_ms = 11'd0;
            3'h1: ramp_ms = `RAMP_SHORT_MS;
            default: ramp_ms = 11'(`RAMP_BASE_MS << (code - 3'h2));
        endcase
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // Storage and port state.

    logic [6:0] led2_torch_level;    // Level code only; bit 7 is not stored.
    logic [3:0] boost_config;        // Bits 3:0; reset bit self-clears.
    logic [6:0] timing_config;       // Ramp and time-out fields.
    logic [6:0] thermistor_config;   // Bits 6:0; bit 7 is not stored.
    port_state_e state;              // Serial port state.
    logic scl_q;                     // Previous clock line level.
    logic sda_q;                     // Previous data line level.
    logic [3:0] bit_cnt;             // Bits moved in the current byte.
    logic [7:0] shift;               // Byte being shifted in or out.
    logic [7:0] ptr;                 // Register pointer, auto-incrementing.
    logic is_read;                   // Direction of the current transfer.
    logic nack;                      // Master declined the next read byte.

    ////////////////////////////////////////////////////////////////////////////
    // Line events and register access decode.

    wire scl_rise = SCL_IN & ~scl_q;
    wire scl_fall = ~SCL_IN & scl_q;
    wire start_cond = SCL_IN & scl_q & sda_q & ~SDA_IN;
    wire stop_cond = SCL_IN & scl_q & ~sda_q & SDA_IN;
    wire byte_done = (bit_cnt == `BITS_PER_BYTE);
    wire addr_hit = (shift[7:1] == DEV_ADDR);
    wire wr_fire = scl_fall & (state == ST_WDATA) & byte_done;
    wire [7:0] wr_data = shift;
    wire wr_led2 = wr_fire & (ptr == `REG_LED2_TORCH);
    wire wr_boost = wr_fire & (ptr == `REG_BOOST);
    wire wr_timing = wr_fire & (ptr == `REG_TIMING);
    wire wr_therm = wr_fire & (ptr == `REG_THERM);
    wire swrst = wr_boost & wr_data[`BOOST_SWRST];
    // Reserved bits and unmapped offsets read as zero; reset bit always reads zero.
    wire [7:0] rd_data = (ptr == `REG_LED2_TORCH) ? {1'b0, led2_torch_level} :
                         (ptr == `REG_BOOST) ? {4'h0, boost_config} :
                         (ptr == `REG_TIMING) ? {1'b0, timing_config} :
                         (ptr == `REG_THERM) ? {1'b0, thermistor_config} : 8'h00;

    ////////////////////////////////////////////////////////////////////////////
    // Register file. A software reset returns every register to its default,
    // in place of storing the written byte.

    always_ff @(posedge CORE_CLK or negedge RESETN) begin
        if (!RESETN) begin
            led2_torch_level <= `RST_LED2_LEVEL;
            boost_config <= `RST_BOOST;
            timing_config <= `RST_TIMING;
            thermistor_config <= `RST_THERM;
        end else if (swrst) begin
            led2_torch_level <= `RST_LED2_LEVEL;
            boost_config <= `RST_BOOST;
            timing_config <= `RST_TIMING;
            thermistor_config <= `RST_THERM;
        end else begin
            // Only the implemented bits are captured, so reserved bits stay zero.
            if (wr_led2) begin
                led2_torch_level <= wr_data[`LEVEL_MSB:0];
            end
            if (wr_boost) begin
                boost_config <= wr_data[`BOOST_SHORT:0];
            end
            if (wr_timing) begin
                timing_config <= wr_data[`RAMP_MSB:0];
            end
            if (wr_therm) begin
                thermistor_config <= wr_data[`THERM_POL:0];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Decoded outputs, registered so that every pin comes from a flip-flop.

    always_ff @(posedge CORE_CLK or negedge RESETN) begin
        if (!RESETN) begin
            TORCH_CURRENT_SETTING <= 7'h00;
            SOFT_RESET <= 1'b0;
            SHORT_DETECT_EN <= 1'b0;
            PASS_MODE <= 1'b0;
            FREQ_4MHZ <= 1'b0;
            ILIM_HIGH <= 1'b0;
            TORCH_RAMP_MS <= 11'd0;
            FLASH_TIMEOUT_MS <= 11'd0;
            TORCH_ACTIVE_LOW <= 1'b0;
            TORCH_PULLDOWN_EN <= 1'b0;
            THERMISTOR_OPEN_EN <= 1'b0;
            THERMISTOR_SHORT_EN <= 1'b0;
            TEMP_THRESHOLD_DV <= 4'h0;
            PIN_TEMP_SENSE <= 1'b0;
        end else begin
            TORCH_CURRENT_SETTING <= led2_torch_level;
            SOFT_RESET <= swrst;
            SHORT_DETECT_EN <= boost_config[`BOOST_SHORT];
            PASS_MODE <= boost_config[`BOOST_PASS];
            FREQ_4MHZ <= boost_config[`BOOST_FREQ];
            ILIM_HIGH <= boost_config[`BOOST_ILIM];
            TORCH_RAMP_MS <= ramp_ms(timing_config[`RAMP_MSB:`RAMP_LSB]);
            FLASH_TIMEOUT_MS <= timeout_ms(timing_config[`TMO_MSB:`TMO_LSB], EXT_TIMEOUT);
            // Polarity is taken as static by the torch logic; software must only
            // change it while disabled, so no glitch filtering is done here.
            TORCH_ACTIVE_LOW <= thermistor_config[`THERM_POL];
            TORCH_PULLDOWN_EN <= ~thermistor_config[`THERM_POL];
            THERMISTOR_OPEN_EN <= thermistor_config[`THERM_OPEN];
            THERMISTOR_SHORT_EN <= thermistor_config[`THERM_SHORT];
            TEMP_THRESHOLD_DV <= thermistor_config[`THRESH_MSB:`THRESH_LSB] + `THRESH_BASE_DV;
            PIN_TEMP_SENSE <= thermistor_config[`THERM_FUNC];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Serial port slave. Bits are sampled on the clock line's rise and the data
    // line is changed only after its fall, so the slave never makes a false start.

    always_ff @(posedge CORE_CLK or negedge RESETN) begin
        if (!RESETN) begin
            scl_q <= 1'b1;
            sda_q <= 1'b1;
            state <= ST_IDLE;
            bit_cnt <= 4'h0;
            shift <= 8'h00;
            ptr <= 8'h00;
            is_read <= 1'b0;
            nack <= 1'b0;
            SDA_OUT <= 1'b0;
            SDA_OE <= 1'b0;
        end else begin
            scl_q <= SCL_IN;
            sda_q <= SDA_IN;
            if (start_cond) begin
                // A start, repeated or not, always restarts address reception.
                state <= ST_ADDR;
                bit_cnt <= 4'h0;
                SDA_OE <= 1'b0;
            end else if (stop_cond) begin
                state <= ST_IDLE;
                SDA_OE <= 1'b0;
            end else if (scl_rise) begin
                if (state == ST_RDATA_ACK) begin
                    nack <= SDA_IN;
                end else begin
                    shift <= {shift[6:0], SDA_IN};
                    bit_cnt <= bit_cnt + 4'h1;
                end
            end else if (scl_fall) begin
                case (state)
                    ST_ADDR: begin
                        if (byte_done) begin
                            state <= addr_hit ? ST_ADDR_ACK : ST_IDLE;
                            SDA_OE <= addr_hit;
                            is_read <= shift[`RW_BIT];
                        end
                    end
                    ST_ADDR_ACK: begin
                        bit_cnt <= 4'h0;
                        if (is_read) begin
                            state <= ST_RDATA;
                            shift <= rd_data;
                            SDA_OE <= ~rd_data[7];
                        end else begin
                            state <= ST_PTR;
                            SDA_OE <= 1'b0;
                        end
                    end
                    ST_PTR, ST_WDATA: begin
                        if (byte_done) begin
                            state <= (state == ST_PTR) ? ST_PTR_ACK : ST_WDATA_ACK;
                            SDA_OE <= 1'b1;
                            if (state == ST_PTR) begin
                                ptr <= shift;
                            end else begin
                                ptr <= ptr + 8'h01;
                            end
                        end
                    end
                    ST_PTR_ACK, ST_WDATA_ACK: begin
                        state <= ST_WDATA;
                        bit_cnt <= 4'h0;
                        SDA_OE <= 1'b0;
                    end
                    ST_RDATA: begin
                        if (byte_done) begin
                            state <= ST_RDATA_ACK;
                            SDA_OE <= 1'b0;
                            ptr <= ptr + 8'h01;
                        end else begin
                            // The clock rise has already moved the next bit to the top,
                            // so shifting again here would skip every other bit.
                            SDA_OE <= ~shift[7];
                        end
                    end
                    ST_RDATA_ACK: begin
                        bit_cnt <= 4'h0;
                        if (nack) begin
                            state <= ST_IDLE;
                        end else begin
                            state <= ST_RDATA;
                            shift <= rd_data;
                            SDA_OE <= ~rd_data[7];
                        end
                    end
                    default: begin
                        state <= state;
                    end
                endcase
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Assertions.

    property p_led2_store;
        @(posedge CORE_CLK) disable iff (!RESETN)
        wr_led2 |-> ##2 TORCH_CURRENT_SETTING == $past(wr_data[6:0], 2);
    endproperty
    a_led2_store: assert property (p_led2_store) else $error("Torch level not stored.");

    property p_swrst;
        @(posedge CORE_CLK) disable iff (!RESETN)
        swrst |-> ##1 SOFT_RESET ##1 (SHORT_DETECT_EN && ILIM_HIGH && !PASS_MODE && !FREQ_4MHZ);
    endproperty
    a_swrst: assert property (p_swrst) else $error("Software reset did not restore defaults.");

    property p_boost_fields;
        @(posedge CORE_CLK) disable iff (!RESETN)
        (wr_boost && !wr_data[7]) |-> ##2 {SHORT_DETECT_EN, PASS_MODE, FREQ_4MHZ, ILIM_HIGH}
            == $past(wr_data[3:0], 2);
    endproperty
    a_boost_fields: assert property (p_boost_fields) else $error("Boost field mismatch.");

    property p_pass_stable;
        @(posedge CORE_CLK) disable iff (!RESETN)
        (!wr_boost && !swrst) [*3] |-> $stable(PASS_MODE);
    endproperty
    a_pass_stable: assert property (p_pass_stable) else $error("Pass mode moved without a write.");

    property p_timeout;
        @(posedge CORE_CLK) disable iff (!RESETN)
        wr_timing |-> ##2 FLASH_TIMEOUT_MS == timeout_ms($past(wr_data[3:0], 2), EXT_TIMEOUT);
    endproperty
    a_timeout: assert property (p_timeout) else $error("Time-out decode mismatch.");

    property p_timeout_range;
        @(posedge CORE_CLK) disable iff (!RESETN)
        $past(RESETN) |-> FLASH_TIMEOUT_MS <= (EXT_TIMEOUT ? 11'd1600 : 11'd400);
    endproperty
    a_timeout_range: assert property (p_timeout_range) else $error("Time-out out of range.");

    property p_polarity;
        @(posedge CORE_CLK) disable iff (!RESETN)
        $past(RESETN) |-> TORCH_ACTIVE_LOW != TORCH_PULLDOWN_EN;
    endproperty
    a_polarity: assert property (p_polarity) else $error("Pull-down not opposite to polarity.");

    property p_threshold;
        @(posedge CORE_CLK) disable iff (!RESETN)
        wr_therm |-> ##2 (TEMP_THRESHOLD_DV == $past(wr_data[3:1], 2) + 4'd2)
            && PIN_TEMP_SENSE == $past(wr_data[0], 2);
    endproperty
    a_threshold: assert property (p_threshold) else $error("Threshold decode mismatch.");

    property p_reserved_zero;
        @(posedge CORE_CLK) disable iff (!RESETN)
        (ptr == `REG_LED2_TORCH || ptr == `REG_TIMING || ptr == `REG_THERM) |-> !rd_data[7];
    endproperty
    a_reserved_zero: assert property (p_reserved_zero) else $error("Reserved bit read as one.");

    property p_ramp;
        @(posedge CORE_CLK) disable iff (!RESETN)
        (wr_timing && wr_data[6:4] == 3'h7) |-> ##2 TORCH_RAMP_MS == 11'd1024;
    endproperty
    a_ramp: assert property (p_ramp) else $error("Ramp decode mismatch.");

endmodule

// file: tb/flash_driver_config_regs_test.sv
// Self-checking bench for the configuration slice, driving the two-wire port as bus master.
// Assumes flash_cfg_regs, its package and its header are compiled first; no other model is needed.
`timescale 1ns/100ps
`include "flash_cfg_defs.svh"

module flash_driver_config_regs_test;
    import flash_cfg_pkg::*;

    localparam logic [6:0] ADDR = 7'h10; // Matches the default bus address of the block.

    logic core_clk;
    logic resetn;
    logic scl;
    logic sda_m; // Master side of the data line, high means released.
    wire logic sda_oe;
    wire logic sda_oe_ext;
    wire logic sda_out; // Level driven while the enable is high; must be low for open drain.
    // The line has a pull-up, so it is low only when somebody pulls it.
    wire logic sda_w = sda_m & (~sda_oe | sda_out) & ~sda_oe_ext;
    level_t torch;
    logic soft_rst, short_en, pass, freq, ilim, act_low, pd_en, open_en, tshort_en, temp_sense;
    ms_t ramp, tmo, tmo_ext;
    dv_t dv;
    int err_total; // Mismatches seen.
    int compares; // Comparisons made.
    int sr_count = 0; // Cycles in which the software reset pulse was seen.
    logic [7:0] rd;
    logic ack;
    logic [7:0] def_val [4] = '{8'h3F, 8'h09, 8'h1A, 8'h08};

    ////////////////////////////////////////////////////////////////////////////////////////////////
    // Standard part and the extended time-out part share one bus; both answer identically.
    flash_cfg_regs #(.DEV_ADDR(ADDR), .EXT_TIMEOUT(1'b0)) dut_u (
        .CORE_CLK(core_clk), .RESETN(resetn), .SCL_IN(scl), .SDA_IN(sda_w), .SDA_OUT(sda_out), .SDA_OE(sda_oe),
        .TORCH_CURRENT_SETTING(torch), .SOFT_RESET(soft_rst), .SHORT_DETECT_EN(short_en), .PASS_MODE(pass),
        .FREQ_4MHZ(freq), .ILIM_HIGH(ilim), .TORCH_RAMP_MS(ramp), .FLASH_TIMEOUT_MS(tmo),
        .TORCH_ACTIVE_LOW(act_low), .TORCH_PULLDOWN_EN(pd_en), .THERMISTOR_OPEN_EN(open_en),
        .THERMISTOR_SHORT_EN(tshort_en), .TEMP_THRESHOLD_DV(dv), .PIN_TEMP_SENSE(temp_sense));

    flash_cfg_regs #(.DEV_ADDR(ADDR), .EXT_TIMEOUT(1'b1)) dut_ext_u (
        .CORE_CLK(core_clk), .RESETN(resetn), .SCL_IN(scl), .SDA_IN(sda_w), .SDA_OUT(), .SDA_OE(sda_oe_ext),
        .TORCH_CURRENT_SETTING(), .SOFT_RESET(), .SHORT_DETECT_EN(), .PASS_MODE(), .FREQ_4MHZ(), .ILIM_HIGH(),
        .TORCH_RAMP_MS(), .FLASH_TIMEOUT_MS(tmo_ext), .TORCH_ACTIVE_LOW(), .TORCH_PULLDOWN_EN(),
        .THERMISTOR_OPEN_EN(), .THERMISTOR_SHORT_EN(), .TEMP_THRESHOLD_DV(), .PIN_TEMP_SENSE());

    ////////////////////////////////////////////////////////////////////////////////////////////////
    // A 50 MHz core clock.
    initial begin
        core_clk = 1'b0;
        forever #10 core_clk = ~core_clk;
    end

    // Count every cycle of the reset pulse, so a stretched pulse is caught as well as a missing one.
    always @(posedge core_clk) begin
        if (soft_rst === 1'b1) begin
            sr_count <= sr_count + 1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////////////////////
    // Compare one value and report a mismatch at once.
    task automatic chk(input logic [10:0] got, input logic [10:0] exp, input string what);
        compares++;
        if (got !== exp) begin
            err_total++;
            $display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask

    // Half a serial clock period; six core cycles keeps well above the minimum of four.
    task automatic hp;
        repeat (6) @(posedge core_clk);
    endtask

    // Start or repeated start: data falls while the clock is high.
    task automatic start_cond;
        @(posedge core_clk);
        sda_m <= 1'b1;
        hp();
        scl <= 1'b1;
        hp();
        sda_m <= 1'b0;
        hp();
        scl <= 1'b0;
    endtask

    // Stop: data rises while the clock is high, then the bus rests.
    task automatic stop_cond;
        @(posedge core_clk);
        sda_m <= 1'b0;
        hp();
        scl <= 1'b1;
        hp();
        sda_m <= 1'b1;
        hp();
    endtask

    // One bit; data moves one core cycle after the clock fall so the two never change together.
    task automatic bit_cycle(input logic v, output logic seen);
        @(posedge core_clk);
        sda_m <= v;
        hp();
        scl <= 1'b1;
        hp();
        seen = sda_w;
        scl <= 1'b0;
    endtask

    // Eight bits MSB first, then the slave acknowledge, which is low when given.
    task automatic send_byte(input logic [7:0] b, output logic acked);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            bit_cycle(b[i], s);
        end
        bit_cycle(1'b1, s);
        acked = (s === 1'b0);
    endtask

    // Eight bits from the slave, then the master acknowledge or not.
    task automatic recv_byte(output logic [7:0] b, input logic mack);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            bit_cycle(1'b1, b[i]);
        end
        bit_cycle(~mack, s);
    endtask

    // Write one or two bytes from a pointer; the address acknowledge is checked against the match.
    task automatic reg_write(input logic [6:0] a, input logic [7:0] p, input logic [7:0] d0,
                             input logic [7:0] d1, input int n);
        start_cond();
        send_byte({a, 1'b0}, ack);
        chk(ack, a === ADDR, "address ack");
        if (ack === 1'b1) begin
            send_byte(p, ack);
            chk(ack, 1'b1, "pointer ack");
            send_byte(d0, ack);
            chk(ack, 1'b1, "data ack");
            if (n > 1) begin
                send_byte(d1, ack);
                chk(ack, 1'b1, "data ack");
            end
        end
        stop_cond();
    endtask

    // Set the pointer, then read one byte after a repeated start.
    task automatic reg_read(input logic [7:0] p, output logic [7:0] d);
        start_cond();
        send_byte({ADDR, 1'b0}, ack);
        chk(ack, 1'b1, "address ack");
        send_byte(p, ack);
        chk(ack, 1'b1, "pointer ack");
        start_cond();
        send_byte({ADDR, 1'b1}, ack);
        chk(ack, 1'b1, "read address ack");
        recv_byte(d, 1'b0);
        stop_cond();
    endtask

    // Expected time-out in ms: fine steps up to code 9, coarse steps above.
    function automatic logic [10:0] exp_tmo(input logic [3:0] c);
        return (c <= 4'h9) ? 11'h00A * (c + 11'h001) : 11'h064 + 11'h032 * (c - 11'h009);
    endfunction

    // Expected ramp in ms: none, one, then doubling from 32.
    function automatic logic [10:0] exp_ramp(input logic [2:0] r);
        return (r == 3'h0) ? 11'h000 : (r == 3'h1) ? 11'h001 : 11'h020 << (r - 3'h2);
    endfunction

    ////////////////////////////////////////////////////////////////////////////////////////////////
    // Print the counts and the verdict, then end the run.
    task automatic report_and_stop;
        $display("Comparisons %0d, mismatches %0d", compares, err_total);
        if (err_total == 0 && compares > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    // The tests need about half a millisecond; twice that means a hang.
    initial begin
        #1000000;
        err_total++;
        $display("Error at %0t: run timed out", $time);
        report_and_stop();
    end

    ////////////////////////////////////////////////////////////////////////////////////////////////
    // Main sequence.
    initial begin
        err_total = 0;
        compares = 0;
        scl = 1'b1;
        sda_m = 1'b1;
        resetn = 1'b0;
        repeat (20) @(posedge core_clk);
        resetn <= 1'b1;
        repeat (3) @(posedge core_clk);
        // Decoded defaults straight after reset.
        chk(torch, 7'h3F, "level default");
        chk(short_en, 1'b1, "short detect default");
        chk(pass, 1'b0, "pass default");
        chk(freq, 1'b0, "frequency default");
        chk(ilim, 1'b1, "limit default");
        chk(ramp, 11'h001, "ramp default");
        chk(tmo, 11'h096, "time-out default");
        chk(tmo_ext, 11'h258, "extended time-out default");
        chk({act_low, pd_en}, 2'h1, "polarity default");
        chk({open_en, tshort_en}, 2'h0, "fault enables default");
        chk(dv, 4'h6, "threshold default");
        chk(temp_sense, 1'b0, "pin function default");
        for (int i = 0; i < 4; i++) begin
            reg_read(`REG_LED2_TORCH + i[7:0], rd);
            chk(rd, def_val[i], "register default");
        end
        // The reserved top bit of the level register is dropped.
        reg_write(ADDR, `REG_LED2_TORCH, 8'hFF, 8'h00, 1);
        chk(torch, 7'h7F, "level all ones");
        reg_read(`REG_LED2_TORCH, rd);
        chk(rd, 8'h7F, "level readback");
        // Two bytes in one transfer; the pointer moves on to the boost register.
        reg_write(ADDR, `REG_LED2_TORCH, 8'h12, 8'h7E, 2);
        chk(torch, 7'h12, "level code");
        chk({short_en, pass, freq, ilim}, 4'hE, "boost bits set");
        reg_read(`REG_BOOST, rd);
        chk(rd, 8'h0E, "boost readback");
        reg_write(ADDR, `REG_BOOST, 8'h01, 8'h00, 1);
        chk({short_en, pass, freq, ilim}, 4'h1, "boost bits cleared");
        // Every time-out code, with the ramp codes cycling beside it.
        for (int i = 0; i < 16; i++) begin
            reg_write(ADDR, `REG_TIMING, {1'b1, i[2:0], i[3:0]}, 8'h00, 1);
            chk(tmo, exp_tmo(i[3:0]), "time-out");
            chk(tmo_ext, exp_tmo(i[3:0]) << 2, "extended time-out");
            chk(ramp, exp_ramp(i[2:0]), "ramp");
            reg_read(`REG_TIMING, rd);
            chk(rd, {1'b0, i[2:0], i[3:0]}, "timing readback");
        end
        // Polarity is changed here only because the device is never enabled in this bench.
        reg_write(ADDR, `REG_THERM, 8'hFF, 8'h00, 1);
        chk({act_low, pd_en}, 2'h2, "polarity low");
        chk({open_en, tshort_en}, 2'h3, "fault enables on");
        chk(dv, 4'h9, "threshold top");
        chk(temp_sense, 1'b1, "pin temperature");
        reg_read(`REG_THERM, rd);
        chk(rd, 8'h7F, "thermistor readback");
        for (int i = 0; i < 8; i++) begin
            reg_write(ADDR, `REG_THERM, {4'h0, i[2:0], 1'b0}, 8'h00, 1);
            chk(dv, {1'b0, i[2:0]} + 4'h2, "threshold code");
            chk({act_low, pd_en, open_en, tshort_en, temp_sense}, 5'h08, "thermistor bits clear");
        end
        // An unmapped pointer takes the write and reads as zero.
        reg_write(ADDR, 8'h0A, 8'h55, 8'h00, 1);
        reg_read(8'h0A, rd);
        chk(rd, 8'h00, "unmapped readback");
        // Another address gets no acknowledge and changes nothing.
        reg_write(ADDR ^ 7'h01, `REG_LED2_TORCH, 8'h00, 8'h00, 1);
        chk(torch, 7'h12, "level after foreign address");
        // Software reset: one pulse, and every register of the slice back at its default.
        chk(sr_count[10:0], 11'h000, "no reset pulse yet");
        reg_write(ADDR, `REG_BOOST, 8'h80, 8'h00, 1);
        chk(sr_count[10:0], 11'h001, "reset pulse");
        chk(torch, 7'h3F, "level after reset");
        chk(tmo, 11'h096, "time-out after reset");
        chk(ramp, 11'h001, "ramp after reset");
        chk({dv, ilim, short_en}, 6'h1B, "threshold and boost after reset");
        reg_read(`REG_BOOST, rd);
        chk(rd, 8'h09, "boost readback after reset");
        report_and_stop();
    end
endmodule
